//--- hdl/safe_input_speed_monitor.sv
// Safe input evaluation, limited speed supervision and torque output control
`timescale 1ns/1ps
// Contract
// - Either input selects limited speed with code 1 or code 2.
// - Start-ramp option resets to 0, no ramp phase.
// - Ramp time 0.1 s to 3600.0 s in 0.1 s steps, default 1.0 s.
// - Active limited speed keeps comparing speed to limit until deactivated.
// - Cut-off speed 120 to 10000 RPM, default 270 RPM.
// - Safe speed limit 1 to 9999 RPM, default 150 RPM.
// - Overspeed triggers torque-off or stop-one reaction, default torque-off.
// - Stop-one reaction only when an input is set to stop-one.
// - Output self-test fault raises alarm and drops the output together.
// - Falling edge or low level activates; steady high leaves inactive.
// - Input one: torque, stop, speed; input two may also reset.
// - Rising edge on input two set to reset resets the device.
// - Automatic or manual reset for the function on input one.
// - Output low on internal, limit, stop-one, power-up test, external fault.
// - After input fault or power-up test, reset needs both inputs off.
// - Functions and failures stay latched until a reset clears them.
// - Drive alarm first; one reset clears alarm, another the function.
// - Channels checked for consistency per sensor type.
// - Discrepancy tolerated for set time, default 10 ms, then fault.
// - Either channel falling activates at once, no tolerance delay.
// - Optional filter suppresses short pulses and contact bounce.
// - Break, antivalent and transistor pairs; two make contacts refused.
// - Change taken after stable time; never settling gives a fault.
// - With ramp, limit checking starts after ramp time expires.
// - Speed at or above limit while monitoring gives a limit fault.

module safe_input_speed_monitor
	import safe_mon_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [1:0] safe_input_one,
	input wire logic [1:0] safe_input_two,
	input wire logic [13:0] speed_rpm,
	input wire logic output_readback,
	input wire logic drive_fault,
	input wire logic external_fail,
	output logic safe_torque_output
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ready;
		logic [31:0] rdata;
		logic wr_pend;
		logic [3:0] wr_idx;
		cfg_s cfg;
		logic [15:0] ramp_time;
		logic [13:0] cutoff;
		logic [13:0] limit_one;
		logic [13:0] limit_two;
		logic [7:0] disc_ms;
		logic [7:0] stable_ms;
		logic [16:0] ms_div;
		logic [6:0] tenth_div;
		logic [3:0] prev_raw;
		logic [3:0] filt;
		logic [3:0] pend;
		logic [3:0][7:0] stab;
		logic [3:0][7:0] pend_cnt;
		logic [1:0][7:0] disc_cnt;
		logic [1:0] lvl_prev;
		logic [1:0] act;
		logic power_up_self_test;
		logic in_fault;
		logic self;
		logic limit;
		logic ext;
		logic stop_rx;
		logic lsp_prev;
		logic ramping;
		logic [15:0] ramp_cnt;
		logic out_prev;
		logic out;
	} state_s;

	state_s s_ff;
	state_s nxt_s;

	logic [16:0] ms_last;
	assign ms_last = 17'(MS_CYC - 1);

	function automatic logic [15:0] clip(
		input logic [31:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] r;
		if (v < {16'h0000, lo}) begin
			r = lo;
		end else if (v > {16'h0000, hi}) begin
			r = hi;
		end else begin
			r = v[15:0];
		end
		return r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [3:0] raw;
		logic ms_tick;
		logic tenth_tick;
		logic [1:0] lvl;
		logic [1:0] demand;
		logic [2:0] fn [2];
		logic [1:0] typ [2];
		logic la;
		logic lb;
		logic rst_evt;
		logic both_off;
		logic lsp;
		logic use_two;
		logic [13:0] lim;
		logic stop_cfg;
		logic trip;
		status_s st;
		nxt_s = s_ff;
		raw = {safe_input_two, safe_input_one};
		fn[0] = s_ff.cfg.fn_one;
		fn[1] = s_ff.cfg.fn_two;
		typ[0] = s_ff.cfg.type_one;
		typ[1] = s_ff.cfg.type_two;
		lvl = 2'h0;
		demand = 2'h0;
		lsp = 1'b0;
		use_two = 1'b0;
		stop_cfg = 1'b0;
		trip = 1'b0;
		// Defaults keep every local defined on all paths
		ms_tick = 1'b0;
		tenth_tick = 1'b0;
		la = 1'b0;
		lb = 1'b0;
		rst_evt = 1'b0;
		both_off = 1'b0;
		lim = 14'h0000;
		st = '0;

		// Bus slave, zero wait states
		nxt_s.ready = 1'b1;
		nxt_s.wr_pend = 1'b0;
		if (s_ff.wr_pend) begin
			unique case (s_ff.wr_idx)
				IDX_CFG: nxt_s.cfg = hwdata[13:0];
				IDX_RAMP: nxt_s.ramp_time = clip(hwdata, RAMP_MIN, RAMP_MAX);
				IDX_CUTOFF: nxt_s.cutoff = 14'(clip(hwdata, CUTOFF_MIN, CUTOFF_MAX));
				IDX_LIMIT_ONE: nxt_s.limit_one = 14'(clip(hwdata, LIMIT_MIN, LIMIT_MAX));
				IDX_LIMIT_TWO: nxt_s.limit_two = 14'(clip(hwdata, LIMIT_MIN, LIMIT_MAX));
				IDX_DISC: nxt_s.disc_ms = hwdata[7:0];
				IDX_STABLE: nxt_s.stable_ms = hwdata[7:0];
				default: ;
			endcase
		end

		// Millisecond and tenth-second time base
		ms_tick = (s_ff.ms_div == ms_last);
		nxt_s.ms_div = ms_tick ? 17'h0_0000 : s_ff.ms_div + 17'h0_0001;
		tenth_tick = ms_tick && (s_ff.tenth_div == TENTH_MS - 7'h01);
		if (ms_tick) begin
			nxt_s.tenth_div = tenth_tick ? 7'h00 : s_ff.tenth_div + 7'h01;
		end

		// Stable-signal filter per channel
		nxt_s.prev_raw = raw;
		for (int c = 0; c < 4; c++) begin
			if (raw[c] != s_ff.prev_raw[c]) begin
				nxt_s.stab[c] = 8'h00;
			end else if (ms_tick && s_ff.stab[c] != 8'hff) begin
				nxt_s.stab[c] = s_ff.stab[c] + 8'h01;
			end
			if (!s_ff.cfg.filter_en) begin
				nxt_s.filt[c] = raw[c];
				nxt_s.pend[c] = 1'b0;
			end else if (raw[c] == s_ff.prev_raw[c] && s_ff.stab[c] >= s_ff.stable_ms) begin
				nxt_s.filt[c] = raw[c];
				nxt_s.pend[c] = 1'b0;
			end else if (raw[c] != s_ff.filt[c]) begin
				nxt_s.pend[c] = 1'b1;
			end
			if (!s_ff.pend[c]) begin
				nxt_s.pend_cnt[c] = 8'h00;
			end else if (ms_tick && s_ff.pend_cnt[c] != 8'hff) begin
				nxt_s.pend_cnt[c] = s_ff.pend_cnt[c] + 8'h01;
			end
		end

		// Channel pairing and discrepancy
		for (int i = 0; i < 2; i++) begin
			la = s_ff.filt[2*i];
			lb = (typ[i] == TYPE_ANTIVALENT) ? ~s_ff.filt[2*i+1] : s_ff.filt[2*i+1];
			lvl[i] = la & lb;
			demand[i] = ~la | ~lb;
			if (la == lb) begin
				nxt_s.disc_cnt[i] = 8'h00;
			end else if (ms_tick && s_ff.disc_cnt[i] != 8'hff) begin
				nxt_s.disc_cnt[i] = s_ff.disc_cnt[i] + 8'h01;
			end
			if (fn[i] == FN_LIMIT_ONE || fn[i] == FN_LIMIT_TWO) begin
				lsp = lsp | s_ff.act[i];
				use_two = use_two | (s_ff.act[i] & (fn[i] == FN_LIMIT_TWO));
			end
			stop_cfg = stop_cfg | (fn[i] == FN_STOP);
		end
		nxt_s.lvl_prev = lvl;

		// Reset handling
		rst_evt = s_ff.wr_pend && s_ff.wr_idx == IDX_CMD && hwdata[0];
		if (s_ff.cfg.fn_two == FN_RESET && lvl[1] && !s_ff.lvl_prev[1]) begin
			rst_evt = 1'b1;
		end
		// Off means de-energised in the cycle before the request
		both_off = !s_ff.lvl_prev[0] && !s_ff.lvl_prev[1];
		if (rst_evt && !drive_fault) begin
			if (s_ff.power_up_self_test || s_ff.in_fault || s_ff.self || s_ff.limit || s_ff.ext) begin
				if (both_off || !(s_ff.power_up_self_test || s_ff.in_fault)) begin
					nxt_s.power_up_self_test = 1'b0;
					nxt_s.in_fault = 1'b0;
					nxt_s.self = 1'b0;
					nxt_s.limit = 1'b0;
					nxt_s.ext = 1'b0;
					nxt_s.stop_rx = 1'b0;
				end
			end else begin
				nxt_s.act = 2'h0;
			end
		end
		if (!s_ff.cfg.manual && lvl[0] && !s_ff.in_fault) begin
			nxt_s.act[0] = 1'b0;
		end

		// Activation wins over any clear in the same cycle
		for (int i = 0; i < 2; i++) begin
			if (demand[i] && fn[i] != FN_RESET) begin
				nxt_s.act[i] = 1'b1;
			end
			if (s_ff.disc_cnt[i] > s_ff.disc_ms) begin
				nxt_s.in_fault = 1'b1;
			end
			if (typ[i] == TYPE_TWO_MAKE || (i == 0 && fn[0] == FN_RESET)) begin
				nxt_s.in_fault = 1'b1;
			end
		end
		for (int c = 0; c < 4; c++) begin
			if (s_ff.pend_cnt[c] >= UNSETTLE_MS) begin
				nxt_s.in_fault = 1'b1;
			end
		end
		if (external_fail) begin
			nxt_s.ext = 1'b1;
		end
		// Readback may lag a cycle, so only a settled output is judged
		if (s_ff.out == s_ff.out_prev && output_readback != s_ff.out) begin
			nxt_s.self = 1'b1;
		end

		// Limited speed supervision
		lim = use_two ? s_ff.limit_two : s_ff.limit_one;
		nxt_s.lsp_prev = lsp;
		if (!lsp) begin
			nxt_s.ramping = 1'b0;
		end else if (!s_ff.lsp_prev) begin
			if (s_ff.cfg.start_ramp && speed_rpm > lim) begin
				nxt_s.ramping = 1'b1;
				nxt_s.ramp_cnt = s_ff.ramp_time;
			end
		end else if (s_ff.ramping && tenth_tick) begin
			nxt_s.ramp_cnt = s_ff.ramp_cnt - 16'h0001;
			if (s_ff.ramp_cnt <= 16'h0001) begin
				nxt_s.ramping = 1'b0;
			end
		end
		if (lsp && s_ff.lsp_prev) begin
			trip = (!s_ff.ramping && speed_rpm >= lim) || speed_rpm > s_ff.cutoff;
		end
		if (trip) begin
			nxt_s.limit = 1'b1;
			if (s_ff.cfg.stop_react && stop_cfg) begin
				nxt_s.stop_rx = 1'b1;
			end
		end

		// Safe torque output
		nxt_s.out_prev = s_ff.out;
		nxt_s.out = 1'b1;
		if (s_ff.power_up_self_test || s_ff.in_fault || s_ff.self || s_ff.limit || s_ff.ext) begin
			nxt_s.out = 1'b0;
		end
		if (drive_fault || nxt_s.self) begin
			nxt_s.out = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			if (s_ff.act[i] && (fn[i] == FN_TORQUE || fn[i] == FN_STOP)) begin
				nxt_s.out = 1'b0;
			end
		end

		// Read data, registered in the address phase
		st = '{drive_fault: drive_fault, stop_rx: s_ff.stop_rx,
			monitoring: lsp & ~s_ff.ramping, ramping: s_ff.ramping,
			act: s_ff.act, ext: s_ff.ext, limit: s_ff.limit, self: s_ff.self,
			in_fault: s_ff.in_fault, power_up_self_test: s_ff.power_up_self_test, out: s_ff.out};
		nxt_s.rdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready) begin
			nxt_s.wr_pend = hwrite;
			nxt_s.wr_idx = haddr[5:2];
			if (!hwrite && haddr[31:6] == 26'h000_0000) begin
				unique case (haddr[5:2])
					IDX_CFG: nxt_s.rdata = {18'h0_0000, s_ff.cfg};
					IDX_RAMP: nxt_s.rdata = {16'h0000, s_ff.ramp_time};
					IDX_CUTOFF: nxt_s.rdata = {18'h0_0000, s_ff.cutoff};
					IDX_LIMIT_ONE: nxt_s.rdata = {18'h0_0000, s_ff.limit_one};
					IDX_LIMIT_TWO: nxt_s.rdata = {18'h0_0000, s_ff.limit_two};
					IDX_DISC: nxt_s.rdata = {24'h00_0000, s_ff.disc_ms};
					IDX_STABLE: nxt_s.rdata = {24'h00_0000, s_ff.stable_ms};
					IDX_STATUS: nxt_s.rdata = {20'h0_0000, st};
					default: nxt_s.rdata = 32'h0000_0000;
				endcase
			end
			if (haddr[31:6] != 26'h000_0000) begin
				nxt_s.wr_pend = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
			s_ff.cfg <= CFG_RST;
			s_ff.ramp_time <= RAMP_RST;
			s_ff.cutoff <= CUTOFF_RST;
			s_ff.limit_one <= LIMIT_RST;
			s_ff.limit_two <= LIMIT_RST;
			s_ff.disc_ms <= DISC_RST;
			s_ff.stable_ms <= STABLE_RST;
			s_ff.prev_raw <= 4'hf;
			s_ff.filt <= 4'hf;
			// Idle high, so no false reset edge follows reset
			s_ff.lvl_prev <= 2'h3;
			s_ff.power_up_self_test <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hreadyout = s_ff.ready;
	assign hrdata = s_ff.rdata;
	// Every transfer completes, so the response never leaves OKAY
	assign hresp = 1'b0;
	assign safe_torque_output = s_ff.out;

endmodule // safe_input_speed_monitor

//--- pkg/safe_mon_pkg.sv
// Constants, configuration layout and state carriers of the safe input speed monitor
package safe_mon_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [6:0] TENTH_MS = 7'h64;
	localparam logic [7:0] UNSETTLE_MS = 8'h64;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [3:0] IDX_CFG = 4'h0;
	localparam logic [3:0] IDX_RAMP = 4'h1;
	localparam logic [3:0] IDX_CUTOFF = 4'h2;
	localparam logic [3:0] IDX_LIMIT_ONE = 4'h3;
	localparam logic [3:0] IDX_LIMIT_TWO = 4'h4;
	localparam logic [3:0] IDX_DISC = 4'h5;
	localparam logic [3:0] IDX_STABLE = 4'h6;
	localparam logic [3:0] IDX_STATUS = 4'h7;
	localparam logic [3:0] IDX_CMD = 4'h8;

	// ----------------------------------------
	// Function selector and sensor type codes
	// ----------------------------------------
	localparam logic [2:0] FN_TORQUE = 3'h0;
	localparam logic [2:0] FN_LIMIT_ONE = 3'h1;
	localparam logic [2:0] FN_LIMIT_TWO = 3'h2;
	localparam logic [2:0] FN_STOP = 3'h3;
	localparam logic [2:0] FN_RESET = 3'h4;
	localparam logic [1:0] TYPE_ANTIVALENT = 2'h1;
	localparam logic [1:0] TYPE_TWO_MAKE = 2'h3;

	// ----------------------------------------
	// Ranges (ramp in 0.1 s, speeds in RPM, times in ms)
	// ----------------------------------------
	localparam logic [15:0] RAMP_MIN = 16'h0001;
	localparam logic [15:0] RAMP_MAX = 16'h8ca0;
	localparam logic [15:0] CUTOFF_MIN = 16'h0078;
	localparam logic [15:0] CUTOFF_MAX = 16'h2710;
	localparam logic [15:0] LIMIT_MIN = 16'h0001;
	localparam logic [15:0] LIMIT_MAX = 16'h270f;

	// ----------------------------------------
	// Configuration register layout and the register reset values
	// ----------------------------------------
	typedef struct packed {
		logic manual;
		logic filter_en;
		logic stop_react;
		logic start_ramp;
		logic [1:0] type_two;
		logic [1:0] type_one;
		logic [2:0] fn_two;
		logic [2:0] fn_one;
	} cfg_s;

	localparam logic [13:0] CFG_RST = 14'h3000;
	localparam logic [15:0] RAMP_RST = 16'h000a;
	localparam logic [13:0] CUTOFF_RST = 14'h010e;
	localparam logic [13:0] LIMIT_RST = 14'h0096;
	localparam logic [7:0] DISC_RST = 8'h0a;
	localparam logic [7:0] STABLE_RST = 8'h02;

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	typedef struct packed {
		logic drive_fault;
		logic stop_rx;
		logic monitoring;
		logic ramping;
		logic [1:0] act;
		logic ext;
		logic limit;
		logic self;
		logic in_fault;
		logic power_up_self_test;
		logic out;
	} status_s;

endpackage

//--- dv/drive_model.sv
// Drive torque-off input model returning the output readback
`timescale 1ns/1ps
module drive_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic safe_torque_output,
	input wire logic brk,
	output logic output_readback
);
	logic q_ff;
	// Readback lags one cycle; brk inverts it to fake a failed output stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) q_ff <= 1'b0;
		else q_ff <= safe_torque_output;
	end
	assign output_readback = brk ? ~q_ff : q_ff;
endmodule // drive_model

//--- dv/safe_mon_props.sv
// Port checker of the safe input speed monitor
`timescale 1ns/1ps
module safe_mon_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic drive_fault,
	input wire logic external_fail,
	input wire logic output_readback,
	input wire logic safe_torque_output
);
	wire rd = hsel && htrans[1] && !hwrite && hready;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// Bus and output relations
	// ----------------------------------------
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_ready_high: assert property ($past(hresetn) |-> hreadyout)
		else $error("wait state inserted");
	a_idle_rdata: assert property (!$past(rd) |-> hrdata == 32'h0000_0000)
		else $error("hrdata not zero outside read");
	a_unmapped_zero: assert property (rd && haddr[5:2] > 4'h8 |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_drv_rise: assert property ($rose(safe_torque_output) |-> !$past(drive_fault))
		else $error("output rose under drive alarm");
	a_drv_low: assert property (drive_fault |=> !safe_torque_output)
		else $error("output high under drive alarm");
	a_ext_low: assert property (external_fail |-> ##[1:2] !safe_torque_output)
		else $error("output high after external failure");
	a_self_low: assert property (safe_torque_output && !output_readback
		&& $past(safe_torque_output) |=> !safe_torque_output)
		else $error("readback mismatch ignored");
	c_out_up: cover property ($rose(safe_torque_output));
	c_drv: cover property (drive_fault ##1 !drive_fault);
	c_ext: cover property (external_fail);
endmodule // safe_mon_props

bind safe_input_speed_monitor safe_mon_props safe_mon_props_i (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .drive_fault,
	.external_fail, .output_readback, .safe_torque_output);

//--- dv/safe_input_speed_monitor_bench.sv
// Self-checking bench of the safe input speed monitor
`timescale 1ns/1ps
module safe_input_speed_monitor_bench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, torque_off_function, rb;
	logic drv = 1'b0, ext = 1'b0, brk = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'h0, in_one = 2'h3, in_two = 2'h3;
	logic [13:0] speed = 14'h0000;
	logic [31:0] tbl [8] = '{32'h0000_3000, 32'h0000_000a, 32'h0000_010e, 32'h0000_0096,
		32'h0000_0096, 32'h0000_000a, 32'h0000_0002, 32'h0000_0002};
	int error_cnt = 0, total_checks = 0, cyc = 0;
	assign hready = hreadyout;
	// Short millisecond keeps filter and discrepancy counts small
	safe_input_speed_monitor #(.MS_CYC(20)) safe_input_speed_monitor_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .safe_input_one(in_one), .safe_input_two(in_two),
		.speed_rpm(speed), .output_readback(rb), .drive_fault(drv),
		.external_fail(ext), .safe_torque_output(torque_off_function));
	drive_model drive_model_i (.hclk(hclk), .hresetn(hresetn),
		.safe_torque_output(torque_off_function), .brk(brk), .output_readback(rb));
	initial begin
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt = error_cnt + 1;
			conclude();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task rd(input logic [31:0] a, output logic [31:0] r);
		bus(a, 1'b0, 32'h0000_0000, r);
	endtask
	task chw(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task chb(input logic g, input logic e);
		chw({31'h0, g}, {31'h0, e});
	endtask
	task rst;
		wr(32'h0000_0020, 32'h0000_0001);
		tick(4);
	endtask
	task setin(input logic [1:0] v);
		@(posedge hclk);
		in_one <= v;
		in_two <= v;
		tick(60);
	endtask
	// Alarm reset needs both inputs off first, function reset follows
	task clear;
		setin(2'h0);
		rst;
		setin(2'h3);
		rst;
		chb(torque_off_function, 1'b1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_defaults;
		logic [31:0] r;
		chb(torque_off_function, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rd(4 * i, r);
			chw(r, tbl[i]);
		end
		rd(32'h0000_0024, r);
		chw(r, 32'h0000_0000);
		$display("t_defaults done");
	endtask
	task t_reset;
		logic [31:0] r;
		rst;
		rd(32'h0000_001c, r);
		chb(r[1], 1'b1);
		setin(2'h0);
		rst;
		rd(32'h0000_001c, r);
		chb(r[1], 1'b0);
		chb(r[6], 1'b1);
		setin(2'h3);
		chb(torque_off_function, 1'b0);
		rst;
		chb(torque_off_function, 1'b1);
		$display("t_reset done");
	endtask
	task t_filter;
		logic [31:0] r;
		@(posedge hclk);
		in_one <= 2'h0;
		tick(20);
		in_one <= 2'h3;
		tick(60);
		chb(torque_off_function, 1'b1);
		wr(32'h0000_0000, 32'h0000_2000);
		@(posedge hclk);
		in_one <= 2'h2;
		tick(4);
		chb(torque_off_function, 1'b0);
		tick(250);
		rd(32'h0000_001c, r);
		chb(r[2], 1'b1);
		clear;
		$display("t_filter done");
	endtask
	task t_speed;
		logic [31:0] r;
		int lim;
		wr(32'h0000_0010, 32'h0000_00c8);
		for (int i = 1; i < 3; i++) begin
			lim = (i == 1) ? 150 : 200;
			wr(32'h0000_0000, 32'h0000_2000 | i);
			@(posedge hclk);
			speed <= 14'(lim - 1);
			in_one <= 2'h0;
			tick(10);
			rd(32'h0000_001c, r);
			chb(r[9], 1'b1);
			chb(torque_off_function, 1'b1);
			@(posedge hclk);
			speed <= 14'(lim);
			tick(4);
			rd(32'h0000_001c, r);
			chb(r[4], 1'b1);
			chb(torque_off_function, 1'b0);
			@(posedge hclk);
			speed <= 14'h0000;
			clear;
		end
		$display("t_speed done");
	endtask
	task t_faults;
		logic [31:0] r;
		@(posedge hclk);
		ext <= 1'b1;
		drv <= 1'b1;
		@(posedge hclk);
		ext <= 1'b0;
		tick(3);
		chb(torque_off_function, 1'b0);
		rst;
		@(posedge hclk);
		drv <= 1'b0;
		tick(3);
		rd(32'h0000_001c, r);
		chb(r[5], 1'b1);
		chb(torque_off_function, 1'b0);
		rst;
		chb(torque_off_function, 1'b1);
		@(posedge hclk);
		brk <= 1'b1;
		tick(10);
		rd(32'h0000_001c, r);
		chb(r[3], 1'b1);
		chb(torque_off_function, 1'b0);
		@(posedge hclk);
		brk <= 1'b0;
		clear;
		$display("t_faults done");
	endtask
	task t_modes;
		logic [31:0] r;
		// Automatic reset on input one, input two as reset input
		wr(32'h0000_0000, 32'h0000_0020);
		@(posedge hclk);
		in_one <= 2'h0;
		tick(4);
		chb(torque_off_function, 1'b0);
		in_one <= 2'h3;
		tick(4);
		chb(torque_off_function, 1'b1);
		ext <= 1'b1;
		@(posedge hclk);
		ext <= 1'b0;
		tick(3);
		chb(torque_off_function, 1'b0);
		in_two <= 2'h0;
		tick(4);
		in_two <= 2'h3;
		tick(6);
		chb(torque_off_function, 1'b1);
		// Range clamps, then a monitored ramp with stop-one reaction
		wr(32'h0000_0004, 32'h0000_0000);
		rd(32'h0000_0004, r);
		chw(r, 32'h0000_0001);
		wr(32'h0000_0008, 32'h0000_0050);
		rd(32'h0000_0008, r);
		chw(r, 32'h0000_0078);
		wr(32'h0000_0008, 32'h0000_3000);
		rd(32'h0000_0008, r);
		chw(r, 32'h0000_2710);
		wr(32'h0000_0004, 32'h0000_0002);
		wr(32'h0000_0000, 32'h0000_2c19);
		@(posedge hclk);
		speed <= 14'h00c8;
		in_one <= 2'h0;
		tick(10);
		rd(32'h0000_001c, r);
		chb(r[8], 1'b1);
		chb(torque_off_function, 1'b1);
		tick(4100);
		rd(32'h0000_001c, r);
		chb(r[4], 1'b1);
		chb(r[10], 1'b1);
		chb(torque_off_function, 1'b0);
		@(posedge hclk);
		speed <= 14'h0000;
		clear;
		// Two make contacts are refused as an input fault
		wr(32'h0000_0000, 32'h0000_20c0);
		rd(32'h0000_001c, r);
		chb(r[2], 1'b1);
		chb(torque_off_function, 1'b0);
		wr(32'h0000_0000, 32'h0000_2000);
		clear;
		$display("t_modes done");
	endtask
	initial begin
		tick(3);
		hresetn <= 1'b1;
		t_defaults;
		t_reset;
		t_filter;
		t_speed;
		t_faults;
		t_modes;
		conclude;
	end
endmodule // safe_input_speed_monitor_bench
